// ---- verilog/frpbe_pkg.sv ----
package frpbe_pkg;
	// register map (word addresses on the plain port)
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_KEY     = 4'h1;
	localparam logic [3:0] ADDR_PAGE    = 4'h2;
	localparam logic [3:0] ADDR_WORD    = 4'h3;
	localparam logic [3:0] ADDR_STATUS  = 4'h4;
	localparam logic [3:0] ADDR_MASK    = 4'h5;

	// control field positions
	localparam int OP_LSB      = 0;
	localparam int ERASE_BIT   = 6;
	localparam int ALLOW_BIT   = 14;
	localparam int START_BIT   = 15;
	localparam int ERROR_BIT   = 13;
	localparam logic [15:0] CONTROL_WMASK = 16'h404F;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;

	// operation codes
	localparam logic [3:0] OP_ROW_PROGRAM = 4'h1;
	localparam logic [3:0] OP_BLOCK_ERASE = 4'h2;

	// unlock key bytes
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;

	// geometry
	localparam int ROWS_PER_BLOCK = 8;
	localparam int ROW_WORDS      = 64;

	// status bit positions
	localparam int ST_DONE   = 0;
	localparam int ST_REJECT = 1;
	localparam logic [1:0] STATUS_RESET = 2'h0;

	// cycle times in microseconds, derived counts at 25 MHz
	localparam int CLOCK_MHZ        = 25;
	localparam int ERASE_TIME_US    = 20;
	localparam int PROGRAM_TIME_US  = 2;
	localparam int ERASE_CYCLES     = ERASE_TIME_US * CLOCK_MHZ;
	localparam int PROGRAM_CYCLES   = PROGRAM_TIME_US * CLOCK_MHZ;

	typedef enum {
		FS_IDLE,
		FS_KEY1,
		FS_ARMED,
		FS_BUSY
	} frpbe_state_e;

	typedef struct packed {
		logic        start;
		logic        erase;
		logic [7:0]  page;
		logic [15:0] word;
	} frpbe_cmd_s;
endpackage

// ---- verilog/frpbe_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module frpbe_timer
	import frpbe_pkg::*;
#(
	parameter int ERASE_COUNT   = ERASE_CYCLES,
	parameter int PROGRAM_COUNT = PROGRAM_CYCLES
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// command
	input  wire logic load,
	input  wire logic erase,
	// completion
	output logic      done
);
	initial begin
		if (ERASE_COUNT < 1 || PROGRAM_COUNT < 1 || ERASE_COUNT > 65535 ||
			PROGRAM_COUNT > 65535)
			$error("timer counts out of range");
	end

	logic [15:0] remain;
	logic        running;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			remain  <= 16'h0000;
			running <= 1'b0;
		end else if (load) begin
			remain  <= erase ? 16'(ERASE_COUNT - 1) : 16'(PROGRAM_COUNT - 1);
			running <= 1'b1;
		end else if (running) begin
			if (remain == 16'h0000)
				running <= 1'b0;
			else
				remain <= remain - 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			done <= 1'b0;
		else
			done <= running && (remain == 16'h0000) && !load;
	end
endmodule
`default_nettype wire

// ---- verilog/frpbe_top.sv ----
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - rows program one at a time; erase covers an eight-row block
// - op 0010 with erase and allow bits set means block erase
// - page pointer and word register give the erase target address
// - key 55h then AAh must precede any operation
// - start bit after unlock launches the cycle and stalls the processor
// - start bit clears itself when the cycle ends
// - op 0001, erase clear, allow set means row program
// - control register is reset only by power-on reset
module frpbe_top
	import frpbe_pkg::*;
#(
	parameter int ERASE_COUNT   = ERASE_CYCLES,
	parameter int PROGRAM_COUNT = PROGRAM_CYCLES
) (
	// clock and resets
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        porRst,
	// register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	// flash array
	output logic             flashErase,
	output logic             flashProgram,
	output logic      [7:0]  flashPage,
	output logic      [15:0] flashWord,
	// processor and interrupt
	output logic             cpuStall,
	output logic             irq
);
	initial begin
		if (ROWS_PER_BLOCK != 8 || ROW_WORDS != 64)
			$error("unsupported flash geometry");
	end

	frpbe_state_e state;
	logic [15:0]  control;
	logic [7:0]   pagePtr;
	logic [15:0]  wordReg;
	logic [1:0]   status;
	logic [1:0]   mask;
	logic         timerLoad;
	logic         timerDone;
	logic         launch;
	logic         reject;
	frpbe_cmd_s   cmd;

	function automatic logic op_valid(input logic [15:0] c);
		// block erase needs 0010 plus erase; row program needs 0001 no erase
		op_valid = c[ALLOW_BIT] &&
			((c[OP_LSB +: 4] == OP_BLOCK_ERASE && c[ERASE_BIT]) ||
			 (c[OP_LSB +: 4] == OP_ROW_PROGRAM && !c[ERASE_BIT]));
	endfunction

	wire logic wrCtl  = regWr && regAddr == ADDR_CONTROL;
	wire logic wrKey  = regWr && regAddr == ADDR_KEY;
	wire logic anyAcc = regWr || regRd;
	wire logic startReq = wrCtl && regWdata[START_BIT];

	assign launch = startReq && state == FS_ARMED && op_valid(
		{1'b0, regWdata[14:0] & CONTROL_WMASK[14:0]});
	assign reject = startReq && state != FS_BUSY && !launch;

	// key sequence, any other access cancels
	always_ff @(posedge ref_clk) begin
		if (rst || porRst) begin
			state <= FS_IDLE;
		end else begin
			case (state)
				FS_IDLE: begin
					if (wrKey && regWdata[7:0] == KEY_FIRST)
						state <= FS_KEY1;
				end
				FS_KEY1: begin
					if (wrKey && regWdata[7:0] == KEY_SECOND)
						state <= FS_ARMED;
					else if (anyAcc)
						state <= FS_IDLE;
				end
				FS_ARMED: begin
					if (launch)
						state <= FS_BUSY;
					else if (anyAcc)
						state <= FS_IDLE;
				end
				FS_BUSY: begin
					if (timerDone)
						state <= FS_IDLE;
				end
				default: state <= FS_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (porRst) begin
			control <= CONTROL_RESET;
		end else if (state == FS_BUSY && timerDone) begin
			control[START_BIT] <= 1'b0;
		end else if (wrCtl && state != FS_BUSY) begin
			control[14:0] <= regWdata[14:0] & CONTROL_WMASK[14:0];
			control[START_BIT] <= launch;
			control[ERROR_BIT] <= reject;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || porRst) begin
			pagePtr <= 8'h00;
			wordReg <= 16'h0000;
		end else if (state != FS_BUSY) begin
			if (regWr && regAddr == ADDR_PAGE)
				pagePtr <= regWdata[7:0];
			if (regWr && regAddr == ADDR_WORD)
				wordReg <= regWdata;
		end
	end

	always_comb begin
		cmd.start = launch;
		cmd.erase = regWdata[ERASE_BIT];
		cmd.page  = pagePtr;
		// erase aligns to 1024 bytes, eight rows of 64 words
		cmd.word  = regWdata[ERASE_BIT] ? (wordReg & 16'hFC00) :
			(wordReg & 16'hFF80);
	end

	assign timerLoad = cmd.start;

	frpbe_timer #(
		.ERASE_COUNT   (ERASE_COUNT),
		.PROGRAM_COUNT (PROGRAM_COUNT)
	) u_timer (
		.ref_clk (ref_clk),
		.rst     (rst || porRst),
		.load    (timerLoad),
		.erase   (cmd.erase),
		.done    (timerDone)
	);

	always_ff @(posedge ref_clk) begin
		if (rst || porRst) begin
			flashErase   <= 1'b0;
			flashProgram <= 1'b0;
			flashPage    <= 8'h00;
			flashWord    <= 16'h0000;
			cpuStall     <= 1'b0;
		end else if (cmd.start) begin
			flashErase   <= cmd.erase;
			flashProgram <= !cmd.erase;
			flashPage    <= cmd.page;
			flashWord    <= cmd.word;
			cpuStall     <= 1'b1;
		end else if (timerDone) begin
			flashErase   <= 1'b0;
			flashProgram <= 1'b0;
			cpuStall     <= 1'b0;
		end
	end

	// sticky status, write one to clear, set wins
	always_ff @(posedge ref_clk) begin
		if (rst || porRst) begin
			status <= STATUS_RESET;
			mask   <= STATUS_RESET;
		end else begin
			if (regWr && regAddr == ADDR_MASK)
				mask <= regWdata[1:0];
			status[ST_DONE] <= (timerDone && state == FS_BUSY) ||
				(status[ST_DONE] &&
				 !(regWr && regAddr == ADDR_STATUS && regWdata[ST_DONE]));
			status[ST_REJECT] <= reject ||
				(status[ST_REJECT] &&
				 !(regWr && regAddr == ADDR_STATUS && regWdata[ST_REJECT]));
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || porRst)
			irq <= 1'b0;
		else
			irq <= |(status & mask);
	end

	always_ff @(posedge ref_clk) begin
		if (rst || porRst) begin
			regRdata <= 16'h0000;
		end else if (regRd) begin
			case (regAddr)
				ADDR_CONTROL: regRdata <= control;
				ADDR_PAGE:    regRdata <= {8'h00, pagePtr};
				ADDR_WORD:    regRdata <= wordReg;
				ADDR_STATUS:  regRdata <= {14'h0000, status};
				ADDR_MASK:    regRdata <= {14'h0000, mask};
				default:      regRdata <= 16'h0000;
			endcase
		end else begin
			regRdata <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// ---- test/frpbe_flash_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module frpbe_flash_model
	import frpbe_pkg::*;
(
	// flash array side
	input wire logic        ref_clk,
	input wire logic        flashErase,
	input wire logic        flashProgram,
	input wire logic [7:0]  flashPage,
	input wire logic [15:0] flashWord
);
	logic [1:0]  lastOp = 2'h0;
	int          nErase = 0;
	int          nProg = 0;
	logic [23:0] lastAddr = 24'h00_0000;
	always @(posedge ref_clk) begin
		lastOp <= {flashErase, flashProgram};
		if (flashErase && !lastOp[1]) begin
			nErase <= nErase + 1;
			lastAddr <= {flashPage, flashWord};
		end
		if (flashProgram && !lastOp[0]) begin
			nProg <= nProg + 1;
			lastAddr <= {flashPage, flashWord};
		end
	end
endmodule
`default_nettype wire

// ---- test/frpbe_top_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module frpbe_top_checker
	import frpbe_pkg::*;
#(
	parameter int ERASE_COUNT = 6,
	parameter int PROGRAM_COUNT = 3
) (
	// clock and resets
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        porRst,
	// register port
	input wire logic [3:0]  regAddr,
	input wire logic [15:0] regWdata,
	input wire logic        regWr,
	// flash and processor
	input wire logic        flashErase,
	input wire logic        flashProgram,
	input wire logic [15:0] flashWord,
	input wire logic        cpuStall
);
	logic key1;
	logic armed;
	int   stallCnt = 0;
	logic wasRst;
	logic startSeen;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst || porRst);
	// unlock tracking and stall length
	always_ff @(posedge ref_clk) begin
		key1 <= regWr && regAddr == ADDR_KEY
			&& regWdata[7:0] == KEY_FIRST;
		armed <= key1 && regWr && regAddr == ADDR_KEY
			&& regWdata[7:0] == KEY_SECOND;
		stallCnt <= cpuStall ? stallCnt + 1 : 0;
		wasRst <= rst || porRst;
		startSeen <= armed && regWr && regAddr == ADDR_CONTROL
			&& regWdata[START_BIT];
	end
	sequence keyPair;
		regWr && regAddr == ADDR_KEY && regWdata[7:0] == KEY_FIRST
		##1 regWr && regAddr == ADDR_KEY && regWdata[7:0] == KEY_SECOND;
	endsequence
	sequence ctlWr(logic [15:0] v);
		regWr && regAddr == ADDR_CONTROL && regWdata == v;
	endsequence
	chk_erase_launch: assert property (
		keyPair ##1 ctlWr(16'hC042) |=> flashErase && cpuStall)
		else $error("erase not launched");
	chk_prog_launch: assert property (
		keyPair ##1 ctlWr(16'hC001) |=> flashProgram && !flashErase)
		else $error("program not launched");
	chk_locked_start: assert property (
		regWr && regAddr == ADDR_CONTROL && regWdata[START_BIT]
		&& !armed && !cpuStall |=> !cpuStall)
		else $error("start taken without unlock");
	chk_stall_long: assert property (
		cpuStall |-> stallCnt <= ERASE_COUNT + 2)
		else $error("stall too long");
	chk_stall_short: assert property (
		$fell(cpuStall) && !wasRst |-> stallCnt >= PROGRAM_COUNT)
		else $error("stall too short");
	chk_stall_match: assert property (
		cpuStall == (flashErase || flashProgram))
		else $error("stall differs from cycle");
	chk_block_align: assert property (
		flashErase |-> flashWord[9:0] == 10'h000)
		else $error("erase target not block aligned");
	chk_row_align: assert property (
		flashProgram |-> flashWord[6:0] == 7'h00)
		else $error("program target not row aligned");
	chk_erase_length: assert property (
		$fell(flashErase) && !wasRst |-> stallCnt >= ERASE_COUNT)
		else $error("erase cycle too short");
	chk_start_cause: assert property (
		$rose(cpuStall) |-> startSeen)
		else $error("cycle began without unlocked start");
endmodule
bind frpbe_top frpbe_top_checker #(
	.ERASE_COUNT(ERASE_COUNT),
	.PROGRAM_COUNT(PROGRAM_COUNT)
) u_chk (.ref_clk, .rst, .porRst, .regAddr, .regWdata, .regWr,
	.flashErase, .flashProgram, .flashWord, .cpuStall);
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench
	import frpbe_pkg::*;
;
	localparam int EC = 6;
	localparam int PC = 3;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        porRst = 1'b1;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [15:0] regRdata;
	logic        flashErase;
	logic        flashProgram;
	logic [7:0]  flashPage;
	logic [15:0] flashWord;
	logic        cpuStall;
	logic        irq;
	int          n_fail = 0;
	int          n_tests = 0;
	int          n;
	always #20 ref_clk = ~ref_clk;
	frpbe_top #(.ERASE_COUNT(EC), .PROGRAM_COUNT(PC)) dut (.ref_clk,
		.rst, .porRst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.flashErase, .flashProgram, .flashPage, .flashWord, .cpuStall,
		.irq);
	frpbe_flash_model flash (.ref_clk, .flashErase, .flashProgram,
		.flashPage, .flashWord);
	task automatic give_verdict();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		regRd <= 1'b0;
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
	endtask
	task automatic idle();
		regWr <= 1'b0;
		regRd <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
		regWr <= 1'b0;
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 chk(regRdata, exp);
	endtask
	// unlock, launch, then count stalled cycles
	task automatic run(input logic [15:0] cmd);
		wr(ADDR_KEY, 16'h0055);
		wr(ADDR_KEY, 16'h00AA);
		wr(ADDR_CONTROL, cmd);
		idle();
		idle();
		n = 2;
		while (cpuStall === 1'b1) begin
			@(posedge ref_clk);
			#1 n++;
			if (n > 100) begin
				n_fail++;
				give_verdict();
			end
		end
	endtask
	task automatic t_reset();
		rdc(ADDR_CONTROL, 16'h0000);
		rdc(ADDR_STATUS, 16'h0000);
		rdc(4'hF, 16'h0000);
		$display("reset values done");
	endtask
	task automatic t_erase();
		wr(ADDR_PAGE, 16'h0012);
		wr(ADDR_WORD, 16'h07FF);
		rdc(ADDR_PAGE, 16'h0012);
		rdc(ADDR_WORD, 16'h07FF);
		run(16'hC042);
		chk(16'(n >= EC), 16'h0001);
		chk(16'(flash.nErase), 16'h0001);
		chk(flash.lastAddr[15:0], 16'h0400);
		chk({8'h00, flash.lastAddr[23:16]}, 16'h0012);
		rdc(ADDR_CONTROL, 16'h4042);
		rdc(ADDR_STATUS, 16'h0001);
		chk(16'(irq), 16'h0000);
		$display("erase done");
	endtask
	task automatic t_prog();
		wr(ADDR_PAGE, 16'h0013);
		wr(ADDR_WORD, 16'h00C5);
		run(16'hC001);
		chk(16'(n >= PC), 16'h0001);
		chk(16'(flash.nProg), 16'h0001);
		chk(flash.lastAddr[15:0], 16'h0080);
		chk({8'h00, flash.lastAddr[23:16]}, 16'h0013);
		wr(ADDR_PAGE, 16'h0014);
		run(16'hC001);
		chk(16'(flash.nProg), 16'h0002);
		chk({8'h00, flash.lastAddr[23:16]}, 16'h0014);
		rdc(ADDR_CONTROL, 16'h4001);
		$display("program done");
	endtask
	task automatic t_irq();
		wr(ADDR_MASK, 16'h0001);
		rdc(ADDR_MASK, 16'h0001);
		idle();
		idle();
		chk(16'(irq), 16'h0001);
		wr(ADDR_STATUS, 16'h0003);
		idle();
		idle();
		chk(16'(irq), 16'h0000);
		$display("interrupt done");
	endtask
	task automatic t_por();
		rst <= 1'b1;
		idle();
		rst <= 1'b0;
		idle();
		rdc(ADDR_CONTROL, 16'h4001);
		porRst <= 1'b1;
		idle();
		porRst <= 1'b0;
		idle();
		rdc(ADDR_CONTROL, 16'h0000);
		$display("reset kinds done");
	endtask
	task automatic t_refuse();
		wr(ADDR_CONTROL, 16'hC042);
		idle();
		chk(16'(cpuStall), 16'h0000);
		rdc(ADDR_STATUS, 16'h0002);
		wr(ADDR_KEY, 16'h0055);
		wr(ADDR_KEY, 16'h00AA);
		rdc(ADDR_CONTROL, 16'h6042);
		wr(ADDR_CONTROL, 16'hC042);
		idle();
		chk(16'(cpuStall), 16'h0000);
		run(16'hC002);
		chk(16'(flash.nErase), 16'h0001);
		$display("refusals done");
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		porRst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_erase();
		t_prog();
		t_irq();
		t_por();
		t_refuse();
		give_verdict();
	end
endmodule
`default_nettype wire
